// *** include/rtdc_cfg.svh ***
`ifndef RTDC_CFG_SVH
`define RTDC_CFG_SVH
// Register offsets (page 1 word addresses)
`define RTDC_ADDR_W 6
`define RTDC_OFF_OUTCONV 6'h02
`define RTDC_OFF_REF 6'h03
`define RTDC_OFF_TDCFG 6'h05
// Reference register fields
`define RTDC_REF_INT_BIT 4
`define RTDC_REF_DL_HI 3
`define RTDC_REF_DL_LO 2
`define RTDC_REF_APD_BIT 1
`define RTDC_REF_VSEL_BIT 0
`define RTDC_REF_RESET 16'h0002
// Touch-detect configuration fields
`define RTDC_CFG_READY_BIT 6
`define RTDC_CFG_PRE_HI 5
`define RTDC_CFG_PRE_LO 3
`define RTDC_CFG_SENSE_HI 2
`define RTDC_CFG_SENSE_LO 0
`define RTDC_CFG_RESET 16'h0000
// Output converter control
`define RTDC_OCC_PD_BIT 15
`define RTDC_OCC_RESET 16'h0000
// Unmapped read value
`define RTDC_UNMAPPED 16'hFFFF
// Clock rate and time base
`define RTDC_CLK_KHZ 10000
`define RTDC_US_CYC(us) (((us) * `RTDC_CLK_KHZ + 999) / 1000)
// Settling delays, us
`define RTDC_DLY1_US 100
`define RTDC_DLY2_US 500
`define RTDC_DLY3_US 1000
// Precharge times, ns
`define RTDC_PRE0_NS 20000
`define RTDC_PRE1_NS 84000
`define RTDC_PRE2_NS 276000
`define RTDC_PRE3_NS 340000
`define RTDC_PRE4_NS 1044000
`define RTDC_PRE5_NS 1108000
`define RTDC_PRE6_NS 1300000
`define RTDC_PRE7_NS 1364000
// Sense times, ns
`define RTDC_SENSE0_NS 32000
`define RTDC_SENSE1_NS 96000
`define RTDC_SENSE2_NS 544000
`define RTDC_SENSE3_NS 608000
`define RTDC_SENSE4_NS 2080000
`define RTDC_SENSE5_NS 2144000
`define RTDC_SENSE6_NS 2592000
`define RTDC_SENSE7_NS 2656000
`define RTDC_CLK_NS 100
`define RTDC_NS_CYC(ns) (((ns) + `RTDC_CLK_NS - 1) / `RTDC_CLK_NS)
`endif

// *** include/rtdc_pkg.sv ***
package rtdc_pkg;
  // Reference control fields
  typedef struct packed {
    logic int_sel;
    logic [1:0] settle_sel;
    logic auto_pd;
    logic volt_sel;
  } rtdc_ref_type;
  // Touch-detect timer selects
  typedef struct packed {
    logic [2:0] precharge_sel;
    logic [2:0] sense_time_sel;
  } rtdc_tdcfg_type;
  // Host register access
  typedef struct packed {
    logic wr;
    logic rd;
    logic [5:0] addr;
    logic [15:0] wdata;
  } rtdc_bus_type;
  // Reference sequencer states
  typedef enum logic [1:0] {
    RTDC_REF_OFF,
    RTDC_REF_SETTLE,
    RTDC_REF_READY
  } rtdc_seq_type;
  // Touch-detect timer phases
  typedef enum logic [1:0] {
    RTDC_TD_IDLE,
    RTDC_TD_PRECHARGE,
    RTDC_TD_SENSE
  } rtdc_td_type;
endpackage : rtdc_pkg

// *** hw/rtdc_timer.sv ***
`timescale 1ns/1ps
`include "rtdc_cfg.svh"
// Loadable down counter; done is high while the count stands at one
module rtdc_timer
  import rtdc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic load,
  input wire logic [15:0] count,
  output logic busy,
  output logic done
);
  logic [15:0] cnt_ff;
  logic [15:0] nxt_cnt;
  logic done_ff;
  logic nxt_done;

  // Next count; done marks the last counted cycle so a load of N spans exactly N cycles
  always_comb
  begin
    nxt_cnt = cnt_ff;
    if (load)
    begin
      nxt_cnt = count;
    end
    else if (cnt_ff != 16'h0000)
    begin
      nxt_cnt = cnt_ff - 16'h0001;
    end
    nxt_done = (nxt_cnt == 16'h0001);
  end

  // Count registers
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      cnt_ff <= 16'h0000;
      done_ff <= 1'b0;
    end
    else
    begin
      cnt_ff <= nxt_cnt;
      done_ff <= nxt_done;
    end
  end

  assign busy = (cnt_ff != 16'h0000);
  assign done = done_ff;
endmodule : rtdc_timer

// *** hw/rtdc_regs.sv ***
`timescale 1ns/1ps
`include "rtdc_cfg.svh"
// Functional notes
// - Reference bit 4: 1 internal reference, 0 external; resets to 0.
// - Two-bit settle delay 0/100/500/1000 us after reference power-up; resets 00.
// - Auto-power-down bit: 1 off between conversions, 0 always on; resets 1.
// - External source keeps internal reference off; internal with auto-off powers per conversion.
// - Reference bit 0: 0 selects 1.25 V, 1 selects 2.5 V; resets 0.
// - Reference fields read back as written; bits 15 to 5 read zero.
// - Config bit 6 mirrors data-ready pin; low from conversion end until all read.
// - Precharge select bits 5:3 pick 20 us to 1.364 ms before touch sense.
// - Sense select bits 2:0 pick 32 us to 2.656 ms between axis conversions.
// - Power-down flag 1 turns converter off and floats its output; 0 runs it.
module rtdc_regs
  import rtdc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input rtdc_bus_type bus,
  output logic [15:0] rdata,
  input wire logic conv_req,
  output logic conv_start,
  input wire logic conv_done,
  input wire logic [15:0] conv_upd_mask,
  input wire logic [15:0] data_read_mask,
  input wire logic td_start,
  output logic td_precharge,
  output logic td_sense,
  output logic td_done,
  output logic ref_int_sel,
  output logic ref_power_on,
  output logic ref_voltage_select,
  output logic data_ready_pin_n,
  output logic output_converter_powerdown,
  output logic converter_out_enable
);
  rtdc_ref_type ref_ff, nxt_ref;
  rtdc_tdcfg_type cfg_ff, nxt_cfg;
  logic occ_pd_ff, nxt_occ_pd;
  logic [15:0] pend_ff, nxt_pend;
  logic [15:0] rdata_ff, nxt_rdata;
  rtdc_seq_type seq_ff, nxt_seq;
  rtdc_td_type td_ff, nxt_td;
  logic req_ff, nxt_req;
  logic start_ff, nxt_start;
  logic settle_load, settle_done;
  logic td_load, td_tmr_done;
  logic [15:0] settle_cyc, pre_cyc, sense_cyc, td_cyc;
  logic wr_ref, wr_cfg, wr_occ;

  ////////////////////////////////////////////////////////////////////////////
  // Register writes and read mux
  assign wr_ref = bus.wr && (bus.addr == `RTDC_OFF_REF);
  assign wr_cfg = bus.wr && (bus.addr == `RTDC_OFF_TDCFG);
  assign wr_occ = bus.wr && (bus.addr == `RTDC_OFF_OUTCONV);

  always_comb
  begin
    nxt_ref = ref_ff;
    nxt_cfg = cfg_ff;
    nxt_occ_pd = occ_pd_ff;
    nxt_rdata = rdata_ff;
    if (wr_ref)
    begin
      nxt_ref.int_sel = bus.wdata[`RTDC_REF_INT_BIT];
      nxt_ref.settle_sel = bus.wdata[`RTDC_REF_DL_HI:`RTDC_REF_DL_LO];
      nxt_ref.auto_pd = bus.wdata[`RTDC_REF_APD_BIT];
      nxt_ref.volt_sel = bus.wdata[`RTDC_REF_VSEL_BIT];
    end
    if (wr_cfg)
    begin
      nxt_cfg.precharge_sel = bus.wdata[`RTDC_CFG_PRE_HI:`RTDC_CFG_PRE_LO];
      nxt_cfg.sense_time_sel = bus.wdata[`RTDC_CFG_SENSE_HI:`RTDC_CFG_SENSE_LO];
    end
    if (wr_occ)
    begin
      nxt_occ_pd = bus.wdata[`RTDC_OCC_PD_BIT];
    end
    if (bus.rd)
    begin
      case (bus.addr)
        `RTDC_OFF_REF: nxt_rdata = {11'h000, ref_ff};
        `RTDC_OFF_TDCFG: nxt_rdata = {9'h000, data_ready_pin_n, cfg_ff};
        `RTDC_OFF_OUTCONV: nxt_rdata = {occ_pd_ff, 15'h0000};
        default: nxt_rdata = `RTDC_UNMAPPED;
      endcase
    end
  end

  // Data-ready tracking: new updates win over reads in the same cycle
  always_comb
  begin
    nxt_pend = pend_ff & ~data_read_mask;
    if (conv_done)
    begin
      nxt_pend = nxt_pend | conv_upd_mask;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      ref_ff <= rtdc_ref_type'(5'(`RTDC_REF_RESET));
      cfg_ff <= rtdc_tdcfg_type'(6'(`RTDC_CFG_RESET));
      occ_pd_ff <= 1'b0;
      rdata_ff <= 16'h0000;
      pend_ff <= 16'h0000;
    end
    else
    begin
      ref_ff <= nxt_ref;
      cfg_ff <= nxt_cfg;
      occ_pd_ff <= nxt_occ_pd;
      rdata_ff <= nxt_rdata;
      pend_ff <= nxt_pend;
    end
  end

  assign rdata = rdata_ff;
  assign data_ready_pin_n = (pend_ff == 16'h0000);
  assign ref_int_sel = ref_ff.int_sel;
  assign ref_voltage_select = ref_ff.volt_sel;
  assign output_converter_powerdown = occ_pd_ff;
  assign converter_out_enable = ~occ_pd_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Reference power and settle sequencer
  always_comb
  begin
    case (ref_ff.settle_sel)
      2'b01: settle_cyc = 16'(`RTDC_US_CYC(`RTDC_DLY1_US));
      2'b10: settle_cyc = 16'(`RTDC_US_CYC(`RTDC_DLY2_US));
      2'b11: settle_cyc = 16'(`RTDC_US_CYC(`RTDC_DLY3_US));
      default: settle_cyc = 16'h0000;
    endcase
  end

  always_comb
  begin
    nxt_seq = seq_ff;
    nxt_req = req_ff | conv_req;
    nxt_start = 1'b0;
    settle_load = 1'b0;
    case (seq_ff)
      RTDC_REF_OFF:
      begin
        if (!ref_ff.int_sel && nxt_req)
        begin
          nxt_start = 1'b1;
          nxt_req = 1'b0;
        end
        else if (ref_ff.int_sel && (nxt_req || !ref_ff.auto_pd))
        begin
          if (settle_cyc == 16'h0000)
          begin
            nxt_seq = RTDC_REF_READY;
          end
          else
          begin
            settle_load = 1'b1;
            nxt_seq = RTDC_REF_SETTLE;
          end
        end
      end
      RTDC_REF_SETTLE:
      begin
        if (!ref_ff.int_sel)
        begin
          nxt_seq = RTDC_REF_OFF;
        end
        else if (settle_done)
        begin
          nxt_seq = RTDC_REF_READY;
        end
      end
      RTDC_REF_READY:
      begin
        if (!ref_ff.int_sel)
        begin
          nxt_seq = RTDC_REF_OFF;
        end
        else if (nxt_req)
        begin
          nxt_start = 1'b1;
          nxt_req = 1'b0;
        end
        else if (ref_ff.auto_pd && !conv_req)
        begin
          nxt_seq = RTDC_REF_OFF;
        end
      end
      default: nxt_seq = RTDC_REF_OFF;
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      seq_ff <= RTDC_REF_OFF;
      req_ff <= 1'b0;
      start_ff <= 1'b0;
    end
    else
    begin
      seq_ff <= nxt_seq;
      req_ff <= nxt_req;
      start_ff <= nxt_start;
    end
  end

  assign conv_start = start_ff;
  assign ref_power_on = ref_ff.int_sel && (seq_ff != RTDC_REF_OFF);

  rtdc_timer u_settle (
    .ref_clk(ref_clk),
    .reset(reset),
    .load(settle_load),
    .count(settle_cyc),
    .busy(),
    .done(settle_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Touch-detect precharge and sense timing
  always_comb
  begin
    case (cfg_ff.precharge_sel)
      3'h0: pre_cyc = 16'(`RTDC_NS_CYC(`RTDC_PRE0_NS));
      3'h1: pre_cyc = 16'(`RTDC_NS_CYC(`RTDC_PRE1_NS));
      3'h2: pre_cyc = 16'(`RTDC_NS_CYC(`RTDC_PRE2_NS));
      3'h3: pre_cyc = 16'(`RTDC_NS_CYC(`RTDC_PRE3_NS));
      3'h4: pre_cyc = 16'(`RTDC_NS_CYC(`RTDC_PRE4_NS));
      3'h5: pre_cyc = 16'(`RTDC_NS_CYC(`RTDC_PRE5_NS));
      3'h6: pre_cyc = 16'(`RTDC_NS_CYC(`RTDC_PRE6_NS));
      default: pre_cyc = 16'(`RTDC_NS_CYC(`RTDC_PRE7_NS));
    endcase
    case (cfg_ff.sense_time_sel)
      3'h0: sense_cyc = 16'(`RTDC_NS_CYC(`RTDC_SENSE0_NS));
      3'h1: sense_cyc = 16'(`RTDC_NS_CYC(`RTDC_SENSE1_NS));
      3'h2: sense_cyc = 16'(`RTDC_NS_CYC(`RTDC_SENSE2_NS));
      3'h3: sense_cyc = 16'(`RTDC_NS_CYC(`RTDC_SENSE3_NS));
      3'h4: sense_cyc = 16'(`RTDC_NS_CYC(`RTDC_SENSE4_NS));
      3'h5: sense_cyc = 16'(`RTDC_NS_CYC(`RTDC_SENSE5_NS));
      3'h6: sense_cyc = 16'(`RTDC_NS_CYC(`RTDC_SENSE6_NS));
      default: sense_cyc = 16'(`RTDC_NS_CYC(`RTDC_SENSE7_NS));
    endcase
  end

  always_comb
  begin
    nxt_td = td_ff;
    td_load = 1'b0;
    td_cyc = pre_cyc;
    case (td_ff)
      RTDC_TD_IDLE:
      begin
        if (td_start)
        begin
          td_load = 1'b1;
          nxt_td = RTDC_TD_PRECHARGE;
        end
      end
      RTDC_TD_PRECHARGE:
      begin
        if (td_tmr_done)
        begin
          td_cyc = sense_cyc;
          td_load = 1'b1;
          nxt_td = RTDC_TD_SENSE;
        end
      end
      RTDC_TD_SENSE:
      begin
        if (td_tmr_done)
        begin
          nxt_td = RTDC_TD_IDLE;
        end
      end
      default: nxt_td = RTDC_TD_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      td_ff <= RTDC_TD_IDLE;
    end
    else
    begin
      td_ff <= nxt_td;
    end
  end

  assign td_precharge = (td_ff == RTDC_TD_PRECHARGE);
  assign td_sense = (td_ff == RTDC_TD_SENSE);
  assign td_done = (td_ff == RTDC_TD_SENSE) && td_tmr_done;

  rtdc_timer u_td (
    .ref_clk(ref_clk),
    .reset(reset),
    .load(td_load),
    .count(td_cyc),
    .busy(),
    .done(td_tmr_done)
  );
endmodule : rtdc_regs

// *** sim/rtdc_monitor.sv ***
`timescale 1ns/1ps
module rtdc_monitor
  import rtdc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input rtdc_bus_type bus,
  input wire logic [15:0] rdata,
  input wire logic conv_req,
  input wire logic conv_start,
  input wire logic conv_done,
  input wire logic [15:0] conv_upd_mask,
  input wire logic td_start,
  input wire logic td_precharge,
  input wire logic td_sense,
  input wire logic td_done,
  input wire logic ref_int_sel,
  input wire logic ref_power_on,
  input wire logic ref_voltage_select,
  input wire logic data_ready_pin_n,
  input wire logic output_converter_powerdown,
  input wire logic converter_out_enable
);
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (reset);
  ////////////////////////////////////////////////////////////////
  // Touch start while idle, then a held precharge phase
  sequence td_go;
    td_start && !td_precharge && !td_sense;
  endsequence
  sequence pre_run;
    td_precharge [*8];
  endsequence
  td_phase_a: assert property (td_go |=> pre_run)
    else $error("precharge phase not held");
  td_end_a: assert property (td_done |-> td_sense ##1 (!td_sense && !td_precharge))
    else $error("touch done outside sense or no return to idle");
  ref_wr_a: assert property (bus.wr && bus.addr == 6'h03 |=>
    ref_int_sel == $past(bus.wdata[4]) && ref_voltage_select == $past(bus.wdata[0]))
    else $error("reference write not applied");
  ref_rd_a: assert property (bus.rd && bus.addr == 6'h03 |=> rdata[15:5] == 11'h000)
    else $error("reference spare bits set");
  occ_wr_a: assert property (bus.wr && bus.addr == 6'h02 |=>
    output_converter_powerdown == $past(bus.wdata[15]))
    else $error("power-down flag not applied");
  out_en_a: assert property (converter_out_enable != output_converter_powerdown)
    else $error("converter enable wrong");
  ext_off_a: assert property (!ref_int_sel [*3] |-> !ref_power_on)
    else $error("internal reference on");
  ext_go_a: assert property (conv_req && !ref_int_sel |-> ##[1:2] conv_start)
    else $error("external start late");
  go_pulse_a: assert property (conv_start |=> !conv_start)
    else $error("start not a pulse");
  ready_set_a: assert property (conv_done && conv_upd_mask != 16'h0000 |=>
    !data_ready_pin_n)
    else $error("data ready not low");
  ref_live_a: assert property (conv_start && ref_int_sel |-> ref_power_on)
    else $error("start without internal reference powered");
endmodule : rtdc_monitor

// *** sim/rtdc_host.sv ***
`timescale 1ns/1ps
module rtdc_host
  import rtdc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic [15:0] rdata,
  output rtdc_bus_type bus
);
  ////////////////////////////////////////////////////////////////
  // Idle bus from time zero
  initial bus = '{wr: 1'b0, rd: 1'b0, addr: 6'h00, wdata: 16'h0000};
  // One-cycle write strobe; released lines toggle so stale data never looks valid
  task automatic write_reg(input logic [5:0] a, input logic [15:0] v);
    @(negedge ref_clk);
    bus.wr = 1'b1;
    bus.addr = a;
    bus.wdata = v;
    @(negedge ref_clk);
    bus.wr = 1'b0;
    bus.addr = ~a;
    bus.wdata = ~v;
  endtask : write_reg
  // One-cycle read strobe; answer taken once the registered data lands
  task automatic read_reg(input logic [5:0] a, output logic [15:0] v);
    @(negedge ref_clk);
    bus.rd = 1'b1;
    bus.addr = a;
    @(negedge ref_clk);
    bus.rd = 1'b0;
    bus.addr = ~a;
    v = rdata;
  endtask : read_reg
endmodule : rtdc_host

// *** sim/tb_top.sv ***
`timescale 1ns/1ps
module tb_top
  import rtdc_pkg::*;
;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  rtdc_bus_type bus;
  logic [15:0] rdata;
  logic conv_req = 1'b0;
  logic conv_done = 1'b0;
  logic [15:0] conv_upd_mask = 16'h0000;
  logic [15:0] data_read_mask = 16'h0000;
  logic td_start = 1'b0;
  logic conv_start, td_precharge, td_sense, td_done, ref_int_sel, ref_power_on;
  logic ref_voltage_select, data_ready_pin_n, output_converter_powerdown;
  logic converter_out_enable;
  int n_errors = 0;
  int total_checks = 0;
  int n;
  ////////////////////////////////////////////////////////////////
  // 100 ns clock
  always #50 ref_clk = ~ref_clk;
  rtdc_regs uut (.ref_clk, .reset, .bus, .rdata, .conv_req, .conv_start, .conv_done,
    .conv_upd_mask, .data_read_mask, .td_start, .td_precharge, .td_sense, .td_done,
    .ref_int_sel, .ref_power_on, .ref_voltage_select, .data_ready_pin_n,
    .output_converter_powerdown, .converter_out_enable);
  rtdc_host host (.ref_clk, .rdata, .bus);
  ////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic complete_run;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run
  task automatic rchk(input string what, input logic [5:0] a, input logic [15:0] exp);
    logic [15:0] v;
    host.read_reg(a, v);
    chk(what, v, exp);
  endtask : rchk
  function automatic logic pick(input int k);
    return k == 0 ? conv_start : (k == 1 ? td_precharge : td_sense);
  endfunction : pick
  // Counts falling edges until the chosen output reaches lvl, bounded
  task automatic span(input int k, input logic lvl, output int c);
    c = 0;
    while (pick(k) !== lvl)
    begin
      @(negedge ref_clk);
      c++;
      if (c > 30000)
      begin
        n_errors++;
        complete_run();
      end
    end
  endtask : span
  // One conversion request, cycles until its start
  task automatic convert(output int c);
    @(negedge ref_clk);
    conv_req = 1'b1;
    @(negedge ref_clk);
    conv_req = 1'b0;
    span(0, 1'b1, c);
  endtask : convert
  // Touch detect run with measured phase lengths
  task automatic touch(input logic [15:0] cfg, input int pre, input int sns);
    host.write_reg(6'h05, cfg);
    rchk("cfg rd", 6'h05, cfg | 16'h0040);
    @(negedge ref_clk);
    td_start = 1'b1;
    @(negedge ref_clk);
    td_start = 1'b0;
    span(1, 1'b0, n);
    chk("precharge", n[15:0], pre[15:0]);
    span(2, 1'b0, n);
    chk("sense", n[15:0], sns[15:0]);
  endtask : touch
  ////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    repeat (8) @(negedge ref_clk);
    reset = 1'b0;
    rchk("ref rst", 6'h03, 16'h0002);
    rchk("cfg rst", 6'h05, 16'h0040);
    rchk("occ rst", 6'h02, 16'h0000);
    rchk("unmapped", 6'h01, 16'hFFFF);
    host.write_reg(6'h03, 16'hFFFF);
    rchk("ref all", 6'h03, 16'h001F);
    chk("int sel", ref_int_sel, 1'b1);
    chk("volt sel", ref_voltage_select, 1'b1);
    host.write_reg(6'h02, 16'hFFFF);
    rchk("occ all", 6'h02, 16'h8000);
    chk("out en", converter_out_enable, 1'b0);
    chk("occ pd", output_converter_powerdown, 1'b1);
    host.write_reg(6'h02, 16'h0000);
    chk("out en", converter_out_enable, 1'b1);
    chk("occ run", output_converter_powerdown, 1'b0);
    host.write_reg(6'h03, 16'h0002);
    convert(n);
    chk("ext go", n <= 2, 1'b1);
    chk("ext ref", ref_power_on, 1'b0);
    host.write_reg(6'h03, 16'h0000);
    repeat (3) @(negedge ref_clk);
    chk("ext ref0", ref_power_on, 1'b0);
    host.write_reg(6'h03, 16'h0012);
    convert(n);
    chk("int go", n <= 3, 1'b1);
    chk("ref up", ref_power_on, 1'b1);
    repeat (2) @(negedge ref_clk);
    chk("ref down", ref_power_on, 1'b0);
    host.write_reg(6'h03, 16'h0016);
    convert(n);
    chk("settle", n >= 1000 && n <= 1010, 1'b1);
    host.write_reg(6'h03, 16'h001A);
    convert(n);
    chk("settle 500", n >= 5000 && n <= 5010, 1'b1);
    host.write_reg(6'h03, 16'h001E);
    convert(n);
    chk("settle 1000", n >= 10000 && n <= 10010, 1'b1);
    host.write_reg(6'h03, 16'h0010);
    repeat (10) @(negedge ref_clk);
    chk("ref on", ref_power_on, 1'b1);
    @(negedge ref_clk);
    conv_done = 1'b1;
    conv_upd_mask = 16'h0003;
    @(negedge ref_clk);
    conv_done = 1'b0;
    conv_upd_mask = 16'h0000;
    chk("ready set", data_ready_pin_n, 1'b0);
    rchk("ready bit", 6'h05, 16'h0000);
    @(negedge ref_clk);
    data_read_mask = 16'h0001;
    @(negedge ref_clk);
    data_read_mask = 16'h0002;
    chk("ready part", data_ready_pin_n, 1'b0);
    @(negedge ref_clk);
    data_read_mask = 16'h0000;
    chk("ready clr", data_ready_pin_n, 1'b1);
    touch(16'h0000, 200, 320);
    touch(16'h0039, 13640, 960);
    complete_run();
  end
endmodule : tb_top
bind rtdc_regs rtdc_monitor mon (.ref_clk, .reset, .bus, .rdata, .conv_req, .conv_start,
  .conv_done, .conv_upd_mask, .td_start, .td_precharge, .td_sense, .td_done, .ref_int_sel,
  .ref_power_on, .ref_voltage_select, .data_ready_pin_n, .output_converter_powerdown,
  .converter_out_enable);
